// ### eirp_pkg.sv
// Package: constants and types for the external interrupt and reset pin block
package eirp_pkg;

  // ----------------------------------------------------------------
  // Trigger options of the active-low interrupt pin
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EIRP_TRG_FALL  = 2'b00,
    EIRP_TRG_LOW   = 2'b01,
    EIRP_TRG_RISE  = 2'b10,
    EIRP_TRG_ANY   = 2'b11
  } eirp_trig_e;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned EIRP_PORTB_W      = 8;
  localparam int unsigned EIRP_SYNC_W       = EIRP_PORTB_W + 3;
  localparam eirp_trig_e  EIRP_TRIG_RST     = EIRP_TRG_FALL;
  localparam logic        EIRP_EXT_EN_RST   = 1'b1;
  localparam logic        EIRP_WOR_EN_RST   = 1'b0;
  localparam logic        EIRP_PIN_IDLE_HI  = 1'b1;
  localparam logic        EIRP_WAKE_IDLE    = 1'b0;
  localparam logic        EIRP_RST_PIN_DRV  = 1'b0;

  // Sync vector layout: {reset pin, irq pin, wake pin, port B}
  localparam int unsigned EIRP_SY_RST       = EIRP_PORTB_W + 2;
  localparam int unsigned EIRP_SY_IRQ       = EIRP_PORTB_W + 1;
  localparam int unsigned EIRP_SY_WAKE      = EIRP_PORTB_W;
  localparam logic [EIRP_SYNC_W-1:0] EIRP_SYNC_RST =
    {EIRP_PIN_IDLE_HI, EIRP_PIN_IDLE_HI, EIRP_WAKE_IDLE, {EIRP_PORTB_W{EIRP_PIN_IDLE_HI}}};

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    eirp_trig_e trig;
    logic       ext_en;
    logic       wor_en;
  } eirp_cfg_s;

  typedef struct packed {
    eirp_cfg_s  cfg;
    logic       irq_prev;
    logic       ext_pend;
    logic       wor_pend;
    logic       rst_oe;
    logic       rst_drv;
    logic       core_rst;
  } eirp_state_s;

endpackage

// ### eirp_sync.sv
// Two-flop synchroniser for a vector of asynchronous pin levels
`timescale 1ns/1ns
module eirp_sync
  import eirp_pkg::*;
#(
  parameter int unsigned       W       = 1,
  parameter logic [W-1:0]      RST_VAL = '0
) (
  input  wire logic            clock_i,
  input  wire logic            rst_i,
  input  wire logic [W-1:0]    async_i,
  output logic      [W-1:0]    sync_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } eirp_sync_s;

  eirp_sync_s st_r;
  eirp_sync_s st_nxt;

  always_comb begin
    st_nxt.meta = async_i;
    st_nxt.stab = st_r.meta;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_r <= {RST_VAL, RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_o = st_r.stab;

endmodule // eirp_sync

// ### eirp_pins.sv
// External interrupt pin, wired-OR wake inputs and reset pin control
//
// Overview of operation
// R1 - Two select bits pick four trigger options
// R2 - Interrupt pin ignored while its enable clear
// R3 - Select bits writable only with mask set
// R4 - Changing trigger option clears pending request
// R5 - Low reset pin holds logic in reset
// R6 - Internal reset drives reset pin low, open-drain
// R7 - High wake pin raises wired-OR request
// R8 - All eight port B pins give wired-OR; the logic takes only pins set as inputs, on a low level
// R9 - Wired-OR only when enabled; power-on clears enable
// R10 - Sync pins, latch events, hold until serviced
`timescale 1ns/1ns
module eirp_pins
  import eirp_pkg::*;
#(
  parameter int unsigned PB_W = EIRP_PORTB_W
) (
  input  wire logic            clock_i,
  input  wire logic            rst_i,
  input  wire logic            ext_irq_pin_n_i,
  input  wire logic            wired_or_wake_pin_i,
  input  wire logic [PB_W-1:0] port_b_pin_i,
  input  wire logic [PB_W-1:0] port_b_dir_out_i,
  input  wire logic            reset_pin_i,
  output logic                 reset_pin_o,
  output logic                 reset_pin_oe_o,
  input  wire logic            watchdog_timer_reset_i,
  input  wire logic            cpu_irq_mask_i,
  input  wire logic            cfg_wr_i,
  input  wire eirp_cfg_s       cfg_i,
  output eirp_cfg_s            cfg_o,
  input  wire logic            ext_irq_ack_i,
  input  wire logic            wor_irq_ack_i,
  output logic                 ext_irq_req_o,
  output logic                 wor_irq_req_o,
  output logic                 core_reset_o
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [EIRP_SYNC_W-1:0] sync_w;
  logic                   irq_s;
  logic                   wake_s;
  logic                   rstpin_s;
  logic [PB_W-1:0]        pb_s;
  logic                   hold_w;
  logic                   trig_chg_w;
  logic                   ext_evt_w;
  logic                   wor_lvl_w;

  eirp_sync #(
    .W       (EIRP_SYNC_W),
    .RST_VAL (EIRP_SYNC_RST)
  ) u_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .async_i ({reset_pin_i, ext_irq_pin_n_i, wired_or_wake_pin_i, port_b_pin_i}),
    .sync_o  (sync_w)
  ); // R10

  assign rstpin_s = sync_w[EIRP_SY_RST];
  assign irq_s    = sync_w[EIRP_SY_IRQ];
  assign wake_s   = sync_w[EIRP_SY_WAKE];
  assign pb_s     = sync_w[PB_W-1:0];

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  eirp_state_s st_r;
  eirp_state_s st_nxt;

  assign hold_w     = rst_i | ~rstpin_s; // R5
  assign trig_chg_w = cfg_wr_i & cpu_irq_mask_i & (cfg_i.trig != st_r.cfg.trig);

  always_comb begin
    unique case (st_r.cfg.trig) // R1
      EIRP_TRG_FALL: ext_evt_w = st_r.irq_prev & ~irq_s;
      EIRP_TRG_LOW:  ext_evt_w = ~irq_s;
      EIRP_TRG_RISE: ext_evt_w = ~st_r.irq_prev & irq_s;
      EIRP_TRG_ANY:  ext_evt_w = st_r.irq_prev ^ irq_s;
    endcase
  end

  // Port B outputs are excluded; only pins set as inputs can wake
  assign wor_lvl_w = st_r.cfg.wor_en & (wake_s | |(~pb_s & ~port_b_dir_out_i)); // R7 R8 R9

  always_comb begin
    st_nxt          = st_r;
    st_nxt.irq_prev = irq_s;
    st_nxt.rst_oe   = watchdog_timer_reset_i; // R6
    st_nxt.rst_drv  = EIRP_RST_PIN_DRV;
    st_nxt.core_rst = hold_w | watchdog_timer_reset_i;
    if (cfg_wr_i) begin
      st_nxt.cfg.ext_en = cfg_i.ext_en;
      st_nxt.cfg.wor_en = cfg_i.wor_en;
      if (cpu_irq_mask_i) begin
        st_nxt.cfg.trig = cfg_i.trig; // R3
      end
    end
    // Ack clears, new event wins over ack
    if (ext_irq_ack_i) begin
      st_nxt.ext_pend = 1'b0;
    end
    if (st_r.cfg.ext_en && ext_evt_w) begin
      st_nxt.ext_pend = 1'b1; // R2 R10
    end
    // Option change discards stale request, even a same-cycle event
    if (trig_chg_w) begin
      st_nxt.ext_pend = 1'b0; // R4
    end
    if (wor_irq_ack_i) begin
      st_nxt.wor_pend = 1'b0;
    end
    if (wor_lvl_w) begin
      st_nxt.wor_pend = 1'b1; // R10
    end
    if (hold_w) begin
      st_nxt.cfg.trig   = EIRP_TRIG_RST; // R5
      st_nxt.cfg.ext_en = EIRP_EXT_EN_RST;
      st_nxt.irq_prev   = EIRP_PIN_IDLE_HI;
      st_nxt.ext_pend   = 1'b0;
      st_nxt.wor_pend   = 1'b0;
    end
    // Enable survives a pin reset; only power-on clears it
    if (rst_i) begin
      st_nxt.cfg.wor_en = EIRP_WOR_EN_RST; // R9
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_r.cfg.trig   <= EIRP_TRIG_RST;
      st_r.cfg.ext_en <= EIRP_EXT_EN_RST;
      st_r.cfg.wor_en <= EIRP_WOR_EN_RST;
      st_r.irq_prev   <= EIRP_PIN_IDLE_HI;
      st_r.ext_pend   <= 1'b0;
      st_r.wor_pend   <= 1'b0;
      st_r.rst_oe     <= 1'b0;
      st_r.rst_drv    <= EIRP_RST_PIN_DRV;
      st_r.core_rst   <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cfg_o          = st_r.cfg;
  assign ext_irq_req_o  = st_r.ext_pend;
  assign wor_irq_req_o  = st_r.wor_pend;
  assign reset_pin_oe_o = st_r.rst_oe;
  assign reset_pin_o    = st_r.rst_drv;
  assign core_reset_o   = st_r.core_rst;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  property p_trig_low;
    st_r.cfg.trig == EIRP_TRG_LOW && st_r.cfg.ext_en && !irq_s && !hold_w && !trig_chg_w
      |=> ext_irq_req_o;
  endproperty
  a_trig_low: assert property (p_trig_low) else $error("low level not latched"); // R1

  property p_trig_fall;
    st_r.cfg.trig == EIRP_TRG_FALL && !ext_irq_req_o && !ext_evt_w |=> !ext_irq_req_o;
  endproperty
  a_trig_fall: assert property (p_trig_fall) else $error("request without edge"); // R1

  property p_pin_disabled;
    $rose(ext_irq_req_o) |-> $past(st_r.cfg.ext_en);
  endproperty
  a_pin_disabled: assert property (p_pin_disabled) else $error("disabled pin raised request"); // R2

  property p_mask_lock;
    cfg_wr_i && !cpu_irq_mask_i && !hold_w |=> $stable(st_r.cfg.trig);
  endproperty
  a_mask_lock: assert property (p_mask_lock) else $error("select bits changed unmasked"); // R3

  property p_mask_write;
    cfg_wr_i && cpu_irq_mask_i && !hold_w |=> cfg_o.trig == $past(cfg_i.trig);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("masked write lost"); // R3

  property p_trig_clear;
    trig_chg_w |=> !ext_irq_req_o;
  endproperty
  a_trig_clear: assert property (p_trig_clear) else $error("pending kept on option change"); // R4

  property p_pin_hold;
    !rstpin_s |=> !ext_irq_req_o && !wor_irq_req_o && core_reset_o
      && cfg_o.trig == EIRP_TRIG_RST;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("logic not held by reset pin"); // R5

  property p_wdog_drive;
    watchdog_timer_reset_i |=> reset_pin_oe_o && !reset_pin_o && core_reset_o;
  endproperty
  a_wdog_drive: assert property (p_wdog_drive) else $error("reset pin not driven"); // R6

  property p_wdog_release;
    !watchdog_timer_reset_i |=> !reset_pin_oe_o;
  endproperty
  a_wdog_release: assert property (p_wdog_release) else $error("reset pin driven idle"); // R6

  property p_wake;
    st_r.cfg.wor_en && wake_s && !hold_w |=> wor_irq_req_o;
  endproperty
  a_wake: assert property (p_wake) else $error("wake pin ignored"); // R7

  property p_portb;
    st_r.cfg.wor_en && |(~pb_s & ~port_b_dir_out_i) && !hold_w |=> wor_irq_req_o;
  endproperty
  a_portb: assert property (p_portb) else $error("port B wake ignored"); // R8

  property p_wor_off;
    !st_r.cfg.wor_en && !wor_irq_req_o |=> !wor_irq_req_o;
  endproperty
  a_wor_off: assert property (p_wor_off) else $error("wired-OR while disabled"); // R9

  property p_hold_req;
    ext_irq_req_o && !ext_irq_ack_i && !trig_chg_w && !hold_w |=> ext_irq_req_o [*1];
  endproperty
  a_hold_req: assert property (p_hold_req) else $error("request dropped unserviced"); // R10

  c_ext_edge:  cover property (!ext_irq_req_o ##1 ext_irq_req_o ##[1:20] ext_irq_ack_i);
  c_trig_chg:  cover property (ext_irq_req_o && trig_chg_w);
  c_wor_req:   cover property ($rose(wor_irq_req_o));
  c_wdog:      cover property ($rose(reset_pin_oe_o));

endmodule // eirp_pins

// ### eirp_pins_partner.sv
// Pin-side model of the interrupt sources and the reset circuit
`timescale 1ns/1ns
module eirp_pins_partner
  import eirp_pkg::*;
(
  input  wire logic                    irq_low_i,
  input  wire logic                    wake_hi_i,
  input  wire logic [EIRP_PORTB_W-1:0] pb_lvl_i,
  input  wire logic                    ext_rst_i,
  input  wire logic                    reset_pin_o_i,
  input  wire logic                    reset_pin_oe_i,
  output logic                         ext_irq_pin_n_o,
  output logic                         wake_pin_o,
  output logic [EIRP_PORTB_W-1:0]      pb_pin_o,
  output logic                         reset_pin_o
);
  assign ext_irq_pin_n_o = ~irq_low_i;
  assign wake_pin_o      = wake_hi_i;
  assign pb_pin_o        = pb_lvl_i;
  // Pull-up wire: each party can only pull it low, never drive it high
  assign reset_pin_o = ~(ext_rst_i | (reset_pin_oe_i & ~reset_pin_o_i));
endmodule // eirp_pins_partner

// ### eirp_pins_tb_top.sv
// Self-checking testbench for the interrupt and reset pin block
`timescale 1ns/1ns
module eirp_pins_tb_top
  import eirp_pkg::*;
;
  logic clock_i = 0, rst_i = 1, irq_low = 0, wake_hi = 0, ext_rst = 0;
  logic wdog = 0, mask = 1, cfg_wr = 0, eack = 0, wack = 0;
  logic [EIRP_PORTB_W-1:0] pb_lvl = 8'hFF, pb_dir = 8'h00, pb;
  logic irq_n, wake, rpin, rpin_o, rpin_oe, ereq, wreq, core_rst;
  eirp_cfg_s cfg_in = '0, cfg_out;
  int fails = 0, tests_run = 0;

  always #25 clock_i = ~clock_i;

  eirp_pins eirp_pins_i (.clock_i(clock_i), .rst_i(rst_i), .ext_irq_pin_n_i(irq_n),
    .wired_or_wake_pin_i(wake), .port_b_pin_i(pb), .port_b_dir_out_i(pb_dir),
    .reset_pin_i(rpin), .reset_pin_o(rpin_o), .reset_pin_oe_o(rpin_oe),
    .watchdog_timer_reset_i(wdog), .cpu_irq_mask_i(mask), .cfg_wr_i(cfg_wr),
    .cfg_i(cfg_in), .cfg_o(cfg_out), .ext_irq_ack_i(eack), .wor_irq_ack_i(wack),
    .ext_irq_req_o(ereq), .wor_irq_req_o(wreq), .core_reset_o(core_rst));

  eirp_pins_partner eirp_pins_partner_i (.irq_low_i(irq_low), .wake_hi_i(wake_hi),
    .pb_lvl_i(pb_lvl), .ext_rst_i(ext_rst), .reset_pin_o_i(rpin_o),
    .reset_pin_oe_i(rpin_oe), .ext_irq_pin_n_o(irq_n), .wake_pin_o(wake),
    .pb_pin_o(pb), .reset_pin_o(rpin));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    chk(what, {3'h0, exp}, {3'h0, got});
  endtask

  task automatic wr(input logic m, input eirp_trig_e t, input logic e, input logic w);
    mask = m;
    cfg_in = '{t, e, w};
    cfg_wr = 1;
    cyc(1);
    cfg_wr = 0;
    cyc(1);
  endtask

  // Pulse one acknowledge: 1 for the pin request, 0 for wired-OR
  task automatic ack(input logic ext);
    eack = ext;
    wack = ~ext;
    cyc(1);
    eack = 0;
    wack = 0;
  endtask

  // Bounded wait; a hang here counts as a mismatch and ends the run
  task automatic wait_rel;
    for (int k = 0; k < 20 && core_rst !== 1'b0; k++) cyc(1);
    chk1("core_reset_release", 1'b0, core_rst);
    if (core_rst !== 1'b0) tally_and_finish();
  endtask

  // Phase 0 after fall, 1 after ack with pin low, 2 after rise
  function automatic logic exp_trig(input eirp_trig_e t, input int ph);
    case (ph)
      0:       return t != EIRP_TRG_RISE;
      1:       return t == EIRP_TRG_LOW;
      default: return t != EIRP_TRG_FALL;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(66820));
    cyc(16);
    rst_i = 0;
    cyc(2);
    chk("cfg_reset", {EIRP_TRIG_RST, EIRP_EXT_EN_RST, EIRP_WOR_EN_RST}, cfg_out);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      eirp_trig_e t;
      t = eirp_trig_e'(i);
      wr(1, t, 1, 0);
      ack(1);
      cyc(3);
      chk1("idle", 1'b0, ereq);
      irq_low = 1;
      cyc(4);
      chk1("fall", exp_trig(t, 0), ereq);
      ack(1);
      cyc(1);
      chk1("ack_while_low", exp_trig(t, 1), ereq);
      irq_low = 0;
      cyc(4);
      chk1("rise", exp_trig(t, 2), ereq);
      ack(1);
      cyc(1);
      chk1("cleared", 1'b0, ereq);
    end
    $display("test trigger options done");
    wr(1, EIRP_TRG_FALL, 1, 0);
    irq_low = 1;
    cyc(4);
    chk1("pending", 1'b1, ereq);
    wr(1, EIRP_TRG_RISE, 1, 0);
    chk1("trig_change_clear", 1'b0, ereq);
    wr(0, EIRP_TRG_FALL, 0, 0);
    chk("masked_write", {EIRP_TRG_RISE, 2'h0}, cfg_out);
    irq_low = 0;
    cyc(4);
    chk1("disabled_pin", 1'b0, ereq);
    $display("test mask and enable done");
    // Sources: 0-1 wake pin, 2-3 port B input, 4-5 port B output; odd = enabled
    for (int i = 0; i < 6; i++) begin
      int b;
      b = $urandom % EIRP_PORTB_W;
      wr(1, cfg_out.trig, 1, i[0]);
      pb_dir = (i >= 4) ? (8'h01 << b) : 8'h00;
      if (i < 2) wake_hi = 1;
      else pb_lvl[b] = 0;
      cyc(4);
      chk1("wor_req", i[0] && i < 4, wreq);
      ack(0);
      cyc(1);
      chk1("wor_hold", i[0] && i < 4, wreq);
      wake_hi = 0;
      pb_lvl = 8'hFF;
      cyc(3);
      ack(0);
      cyc(1);
      chk1("wor_clear", 1'b0, wreq);
    end
    $display("test wired-or done");
    wr(1, EIRP_TRG_ANY, 0, 1);
    wdog = 1;
    cyc(1);
    chk1("oe_drive", 1'b1, rpin_oe);
    chk1("pin_low", 1'b0, rpin);
    cyc(3);
    wdog = 0;
    wait_rel();
    chk("pin_reset_cfg", {EIRP_TRIG_RST, EIRP_EXT_EN_RST, 1'b1}, cfg_out);
    ext_rst = 1;
    cyc(4);
    chk1("ext_hold", 1'b1, core_rst);
    chk1("no_drive", 1'b0, rpin_oe);
    ext_rst = 0;
    wait_rel();
    $display("test reset pin done");
    tally_and_finish();
  end
endmodule // eirp_pins_tb_top
